// ---- pkg/fsc_pkg.sv ----
// Package for the flash status and configuration register block.
// Assumes one system clock that oversamples the serial link clock.
package fsc_pkg;

    // Serial opcodes and command bytes
    localparam logic [7:0] OP_CFG_READ   = 8'h3F;
    localparam logic [7:0] OP_STAT_READ  = 8'hD7;
    localparam logic [7:0] OP_QUAD_B1    = 8'h3D;
    localparam logic [7:0] OP_QUAD_B2    = 8'h2A;
    localparam logic [7:0] OP_QUAD_B3    = 8'h81;
    localparam logic [7:0] OP_QUAD_EN    = 8'h66;
    localparam logic [7:0] OP_QUAD_DIS   = 8'h67;
    localparam logic [7:0] OP_QUAD_BUF1  = 8'h24;
    localparam logic [7:0] OP_QUAD_BUF2  = 8'h27;
    localparam logic [7:0] OP_QUAD_READ  = 8'h6B;
    localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
    localparam logic [7:0] OP_BUF2_WRITE = 8'h87;

    // Configuration byte layout
    localparam int         CFG_QE_BIT    = 7;
    localparam logic [7:0] CFG_FIXED     = 8'h08;
    localparam logic       CFG_QE_SHIP   = 1'b0;

    // Status word field positions (first byte high; status read sends low byte only)
    localparam int ST_RDY   = 15;
    localparam int ST_PROT  = 9;
    localparam int ST_PSIZE = 8;
    localparam int ST_EPE   = 5;
    localparam int ST_SLE   = 3;
    localparam int ST_PS2   = 2;
    localparam int ST_PS1   = 1;
    localparam int ST_ES    = 0;

    // Configuration write time
    localparam int CLK_HZ            = 20_000_000;
    localparam int CFG_WRITE_TIME_US = 1000;
    localparam int CFG_WRITE_CYCLES  = CFG_WRITE_TIME_US * (CLK_HZ / 1_000_000);

    // Events reported by the array engine
    typedef struct packed {
        logic done;
        logic fail;
        logic aborted;
    } fsc_op_result_t;

    // Serial pin samples
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } fsc_pins_t;

endpackage

// ---- core/fsc_sync.sv ----
// Two flip-flop synchroniser for the serial pins.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module fsc_sync
    import fsc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic      clk_sys,
    input  wire logic      rst_n,
    input  wire logic      clk_en,
    // Raw and synchronised pins
    input  wire fsc_pins_t pins_raw,
    output fsc_pins_t      pins_sync
);
    fsc_pins_t meta_q, meta_d;   // First stage
    fsc_pins_t sync_q, sync_d;   // Second stage

    // Next values: shift one stage
    always_comb begin
        meta_d = pins_raw;
        sync_d = meta_q;
    end

    // Register both stages, idle high on chip select
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            sync_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
        end else if (clk_en) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pins_sync = sync_q;
endmodule
`default_nettype wire

// ---- core/fsc_regs.sv ----
// Status flags and nonvolatile quad configuration register of a serial flash.
// Assumes SPI mode 0 host, clock far slower than clk_sys, array engine on clk_sys.
// Function
// - Error flag refreshed after each program/erase
// - Aborted operation leaves error flag clear
// - Lockdown flag shows lockdown still allowed
// - Buffer two locked while its program suspended
// - Buffer one locked while its program suspended
// - Erase suspended flag follows suspend state
// - Page size bit reports configured size
// - Protect bit reports any protection source
// - Configuration read only while ready
// - Opcode 3F then configuration byte shifts out
// - Configuration byte repeats while clocked
// - Host discards first byte at high speed
// - Chip select high ends read, releases output
// - Configuration held nonvolatile across reset
// - Software reset keeps quad enable
// - Byte: quad bit 7, bit 3 one
// - Quad commands change only bit 7
// - Quad on: quad opcodes, pins become data
// - Quad off: quad opcodes invalid, pins control
// - Configuration program self-timed, shows busy
// - Four-byte sequence ending 66 sets quad
// - Four-byte sequence ending 67 clears quad
// - Ready bit low while busy
// - Error flag at bit 5
`timescale 1ns/1ns
`default_nettype none
module fsc_regs
    import fsc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    input  wire logic           clk_en,
    // Serial pins
    input  wire logic           cs_n_pin,
    input  wire logic           sck_pin,
    input  wire logic           si_pin,
    output logic                so_out,
    output logic                so_oe_n,
    // Quad data line control for the write-protect and reset pins
    output logic                io23_quad_mode,
    output logic                wp_active_n,
    input  wire logic           wp_pin_n,
    output logic                reset_fn_active,
    // Array engine status
    input  wire logic           array_busy,
    input  wire fsc_op_result_t op_result,
    input  wire logic           sw_protect_en,
    input  wire logic           lockdown_disabled,
    input  wire logic           page_is_binary,
    input  wire logic           buf1_prog_susp,
    input  wire logic           buf2_prog_susp,
    input  wire logic           erase_susp,
    input  wire logic           soft_reset,
    // Persistent quad bit storage
    input  wire logic           nv_qe_valid,
    input  wire logic           nv_qe_value,
    output logic                nv_qe_write,
    // Command decode and status outputs
    output logic                quad_cmd_accept,
    output logic                buf1_write_accept,
    output logic                buf2_write_accept,
    output logic [15:0]         device_status_flags
);
    typedef enum { ST_IDLE, ST_OPC, ST_QSEQ, ST_CFGOUT, ST_STATOUT, ST_SINK } fsc_state_t;

    fsc_pins_t  pins;                       // Synchronised pins
    fsc_state_t state_q, state_d;           // Command state
    logic       sck_q, sck_d;               // Previous clock sample
    logic [2:0] bit_q, bit_d;               // Bit position in byte
    logic [7:0] sh_q, sh_d;                 // Input shifter
    logic [1:0] byte_q, byte_d;             // Quad sequence byte count
    logic [1:0] qop_q, qop_d;               // 2: set, 1: clear, 0: none
    logic [7:0] out_q, out_d;               // Output shifter
    logic [15:0] stat_q, stat_d;            // Status word register
    logic       qe_q, qe_d;                 // Quad enable bit
    logic       qe_load_q, qe_load_d;       // Storage value loaded
    logic       pend_q, pend_d;             // Programming pending value
    logic       wr_busy_q, wr_busy_d;       // Configuration write running
    logic [31:0] wr_cnt_q, wr_cnt_d;        // Write timer
    logic       epe_q, epe_d;               // Error flag
    logic       so_q, so_d, oe_n_q, oe_n_d; // Output pin registers
    logic       acc_q, acc_d, b1_q, b1_d, b2_q, b2_d, nvw_q, nvw_d;
    logic       rise, fall, full;
    logic [7:0] byte_in;
    logic       wpn_m_q, wpn_s_q, wpa_q, wpa_d; // Write-protect pin sync and output

    // Pin synchroniser
    fsc_sync u_sync (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .pins_raw  ('{cs_n: cs_n_pin, sck: sck_pin, si: si_pin}),
        .pins_sync (pins)
    );

    // Configuration byte assembly
    function automatic logic [7:0] cfg_byte(input logic qe);
        logic [7:0] b;
        b = CFG_FIXED;
        b[CFG_QE_BIT] = qe;
        return b;
    endfunction

    // Edge and byte detection
    always_comb begin
        rise    = pins.sck & ~sck_q & ~pins.cs_n;
        fall    = ~pins.sck & sck_q & ~pins.cs_n;
        byte_in = {sh_q[6:0], pins.si};
        full    = rise && (bit_q == 3'd7);
    end

    // Serial command engine next state
    always_comb begin
        state_d = state_q;
        sck_d   = pins.sck;
        bit_d   = bit_q;
        sh_d    = sh_q;
        byte_d  = byte_q;
        qop_d   = qop_q;
        out_d   = out_q;
        so_d    = so_q;
        oe_n_d  = oe_n_q;
        acc_d   = 1'b0;
        b1_d    = 1'b0;
        b2_d    = 1'b0;
        if (pins.cs_n) begin
            // Chip select high ends any transfer
            state_d = ST_IDLE;
            oe_n_d  = 1'b1;
            bit_d   = 3'd0;
            byte_d  = 2'd0;
            qop_d   = (state_q == ST_QSEQ && byte_q == 2'd0) ? qop_q : 2'd0;
        end else begin
            if (rise) begin
                sh_d  = byte_in;
                bit_d = bit_q + 3'd1;
            end
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_OPC;
                    qop_d   = 2'd0;
                end
                ST_OPC: if (full) begin
                    // Opcode decode
                    if (byte_in == OP_CFG_READ) begin
                        state_d = (wr_busy_q || array_busy) ? ST_SINK : ST_CFGOUT;
                        out_d   = cfg_byte(qe_q);
                    end else if (byte_in == OP_STAT_READ) begin
                        state_d = ST_STATOUT;
                        out_d   = stat_q[15:8];
                    end else if (byte_in == OP_QUAD_B1 && !wr_busy_q && !array_busy) begin
                        state_d = ST_QSEQ;
                        byte_d  = 2'd1;
                    end else begin
                        state_d = ST_SINK;
                        acc_d = qe_q && (byte_in == OP_QUAD_BUF1 || byte_in == OP_QUAD_BUF2
                                || byte_in == OP_QUAD_READ);
                        b1_d  = !buf1_prog_susp && (byte_in == OP_BUF1_WRITE
                                || (qe_q && byte_in == OP_QUAD_BUF1));
                        b2_d  = !buf2_prog_susp && (byte_in == OP_BUF2_WRITE
                                || (qe_q && byte_in == OP_QUAD_BUF2));
                    end
                end
                ST_QSEQ: if (full) begin
                    // Remaining quad sequence bytes
                    unique case (byte_q)
                        2'd1: begin
                            state_d = (byte_in == OP_QUAD_B2) ? ST_QSEQ : ST_SINK;
                            byte_d  = 2'd2;
                        end
                        2'd2: begin
                            state_d = (byte_in == OP_QUAD_B3) ? ST_QSEQ : ST_SINK;
                            byte_d  = 2'd3;
                        end
                        default: begin
                            byte_d  = 2'd0;
                            qop_d   = (byte_in == OP_QUAD_EN)  ? 2'd2 :
                                      (byte_in == OP_QUAD_DIS) ? 2'd1 : 2'd0;
                            state_d = (qop_d != 2'd0) ? ST_QSEQ : ST_SINK;
                        end
                    endcase
                    if (byte_q == 2'd0) begin
                        state_d = ST_SINK;
                        qop_d   = 2'd0;
                    end
                end
                ST_CFGOUT, ST_STATOUT: begin
                    // Shift out on falling edge, reload every byte
                    if (fall) begin
                        oe_n_d = 1'b0;
                        so_d   = out_q[7];
                        out_d  = {out_q[6:0], out_q[7]};
                        if (bit_q == 3'd0 && state_q == ST_STATOUT) begin
                            out_d = {stat_q[6:0], stat_q[7]};
                            so_d  = stat_q[7];
                        end
                    end
                    if (full && state_q == ST_CFGOUT) begin
                        out_d = cfg_byte(qe_q);
                    end
                end
                ST_SINK: ;
            endcase
        end
    end

    // Quad bit and configuration write timer
    always_comb begin
        qe_d      = qe_q;
        qe_load_d = qe_load_q;
        pend_d    = pend_q;
        wr_busy_d = wr_busy_q;
        wr_cnt_d  = wr_cnt_q;
        nvw_d     = 1'b0;
        if (!qe_load_q && nv_qe_valid) begin
            qe_d      = nv_qe_value;
            qe_load_d = 1'b1;
        end
        if (pins.cs_n && !sck_q && state_q == ST_QSEQ && byte_q == 2'd0 && qop_q != 2'd0) begin
            wr_busy_d = 1'b1;
            wr_cnt_d  = CFG_WRITE_CYCLES;
            pend_d    = qop_q[1];
        end else if (wr_busy_q) begin
            if (wr_cnt_q == 32'd1) begin
                wr_busy_d = 1'b0;
                qe_d      = pend_q;
                nvw_d     = 1'b1;
            end
            wr_cnt_d = wr_cnt_q - 32'd1;
        end
    end

    // Status word and error flag
    always_comb begin
        epe_d = epe_q;
        if (op_result.done) begin
            epe_d = op_result.fail & ~op_result.aborted;
        end
        stat_d           = 16'h0000;
        stat_d[ST_RDY]   = ~(array_busy | wr_busy_q);
        stat_d[ST_PROT]  = sw_protect_en | ~wpn_s_q & ~qe_q;
        wpa_d            = ~(~qe_q & ~wpn_s_q);
        stat_d[ST_PSIZE] = page_is_binary;
        stat_d[ST_EPE]   = epe_q;
        stat_d[ST_SLE]   = ~lockdown_disabled;
        stat_d[ST_PS2]   = buf2_prog_susp;
        stat_d[ST_PS1]   = buf1_prog_susp;
        stat_d[ST_ES]    = erase_susp;
    end

    // Register all state; soft reset leaves quad bit alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE; sck_q <= 1'b0; bit_q <= 3'd0; sh_q <= 8'h00;
            byte_q <= 2'd0; qop_q <= 2'd0; out_q <= 8'h00; so_q <= 1'b0;
            oe_n_q <= 1'b1; acc_q <= 1'b0; b1_q <= 1'b0; b2_q <= 1'b0;
            qe_q <= CFG_QE_SHIP; qe_load_q <= 1'b0; pend_q <= 1'b0;
            wr_busy_q <= 1'b0; wr_cnt_q <= 32'd0; nvw_q <= 1'b0;
            epe_q <= 1'b0; stat_q <= 16'h0000; wpn_m_q <= 1'b1; wpn_s_q <= 1'b1; wpa_q <= 1'b1;
        end else if (clk_en) begin
            state_q <= soft_reset ? ST_SINK : state_d;
            sck_q <= sck_d; bit_q <= bit_d; sh_q <= sh_d; byte_q <= byte_d;
            qop_q <= qop_d; out_q <= out_d; so_q <= so_d; oe_n_q <= oe_n_d;
            acc_q <= acc_d; b1_q <= b1_d; b2_q <= b2_d; wpa_q <= wpa_d; wpn_m_q <= wp_pin_n;
            qe_q <= qe_d; qe_load_q <= qe_load_d; pend_q <= pend_d; wpn_s_q <= wpn_m_q;
            wr_busy_q <= wr_busy_d; wr_cnt_q <= wr_cnt_d; nvw_q <= nvw_d;
            epe_q <= (soft_reset && !op_result.done) ? 1'b0 : epe_d; stat_q <= stat_d;
        end
    end

    // Registered outputs
    always_comb begin
        so_out              = so_q;
        so_oe_n             = oe_n_q;
        io23_quad_mode      = qe_q;
        wp_active_n         = wpa_q;
        reset_fn_active     = ~qe_q;
        quad_cmd_accept     = acc_q;
        buf1_write_accept   = b1_q;
        buf2_write_accept   = b2_q;
        nv_qe_write         = nvw_q;
        device_status_flags = stat_q;
    end
endmodule
`default_nettype wire

// ---- dv/fsc_regs_assertions.sv ----
// Concurrent checks on the ports of the status and configuration block.
// Assumes it is bound to fsc_regs and runs on clk_sys alone.
`timescale 1ns/1ns
`default_nettype none
module fsc_regs_chk
    import fsc_pkg::*;
(
    // Clock, reset, enable
    input wire logic           clk_sys,
    input wire logic           rst_n,
    input wire logic           clk_en,
    // Serial and pin control
    input wire logic           cs_n_pin,
    input wire logic           so_oe_n,
    input wire logic           io23_quad_mode,
    input wire logic           wp_active_n,
    input wire logic           reset_fn_active,
    // Engine status and decode
    input wire logic           array_busy,
    input wire fsc_op_result_t op_result,
    input wire logic           lockdown_disabled,
    input wire logic           buf1_prog_susp,
    input wire logic           buf2_prog_susp,
    input wire logic           erase_susp,
    input wire logic           nv_qe_write,
    input wire logic           quad_cmd_accept,
    input wire logic           buf1_write_accept,
    input wire logic           buf2_write_accept,
    input wire logic [15:0]    device_status_flags
);
    // One domain: shared clock and disable
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !clk_en);

    oe_release_a: assert property (cs_n_pin [*8] |-> so_oe_n)
        else $error("output driven while deselected");
    quad_pins_a: assert property ($stable(io23_quad_mode) |-> reset_fn_active == !io23_quad_mode)
        else $error("reset pin role disagrees with quad bit");
    wp_free_a: assert property (io23_quad_mode && $stable(io23_quad_mode) |-> wp_active_n)
        else $error("write protect active in quad mode");
    err_set_a: assert property (op_result.done && op_result.fail && !op_result.aborted
        |-> ##[1:3] device_status_flags[ST_EPE])
        else $error("error flag not set after failure");
    err_abort_a: assert property (op_result.done && op_result.aborted
        |-> ##[1:3] !device_status_flags[ST_EPE])
        else $error("error flag set after abort");
    busy_rdy_a: assert property (array_busy [*4] |-> !device_status_flags[ST_RDY])
        else $error("ready shown while busy");
    nv_busy_a: assert property (nv_qe_write |-> !$past(device_status_flags[ST_RDY], 3))
        else $error("quad write without busy period");
    buf1_lock_a: assert property (buf1_prog_susp && $past(buf1_prog_susp) |-> !buf1_write_accept)
        else $error("buffer one write taken while suspended");
    buf2_lock_a: assert property (buf2_prog_susp && $past(buf2_prog_susp) |-> !buf2_write_accept)
        else $error("buffer two write taken while suspended");
    quad_off_a: assert property (!io23_quad_mode && !$past(io23_quad_mode) |-> !quad_cmd_accept)
        else $error("quad opcode taken with quad off");
    es_flag_a: assert property ($stable(erase_susp) [*4] |-> device_status_flags[ST_ES] == erase_susp)
        else $error("erase suspend flag wrong");
    sle_flag_a: assert property ($stable(lockdown_disabled) [*4]
        |-> device_status_flags[ST_SLE] == !lockdown_disabled)
        else $error("lockdown flag wrong");
endmodule
bind fsc_regs fsc_regs_chk fsc_regs_chk_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cs_n_pin(cs_n_pin), .so_oe_n(so_oe_n),
    .io23_quad_mode(io23_quad_mode), .wp_active_n(wp_active_n), .array_busy(array_busy),
    .reset_fn_active(reset_fn_active), .op_result(op_result), .erase_susp(erase_susp),
    .lockdown_disabled(lockdown_disabled), .buf1_prog_susp(buf1_prog_susp),
    .buf2_prog_susp(buf2_prog_susp), .nv_qe_write(nv_qe_write), .quad_cmd_accept(quad_cmd_accept),
    .buf1_write_accept(buf1_write_accept), .buf2_write_accept(buf2_write_accept),
    .device_status_flags(device_status_flags));
`default_nettype wire

// ---- dv/fsc_spi_host.sv ----
// Behavioural mode 0 serial host for the flash block.
// Assumes a 400 ns link clock that stands low outside frames.
`timescale 1ns/1ns
`default_nettype none
module fsc_spi_host (
    // Serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so
);
    // Idle: deselected, clock low
    initial begin
        {cs_n, sck, si} = 3'b101;
    end
    // Open a frame
    task automatic sel();
        cs_n = 1'b0;
        #200;
    endtask
    // Shift nb bits MSB first; capture each bit just before the next fall
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            sck = 1'b0;
            si = tx[i];
            #200 sck = 1'b1;
            #199 rx[i] = so;
            #1;
        end
    endtask
    // Close a frame and stop driving the old data value
    task automatic desel();
        sck = 1'b0;
        #200 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- dv/fsc_regs_tb.sv ----
// Self-checking bench for the status and configuration block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module fsc_regs_tb
    import fsc_pkg::*;
;
    // Stimulus, observed outputs, counters
    logic           clk_sys, rst_n, clk_en, array_busy, soft_reset, wp_pin_n, sw_protect_en;
    logic           lockdown_disabled, page_is_binary, erase_susp, buf1_prog_susp;
    logic           buf2_prog_susp, nv_qe_valid, nv_qe_value, so_out, so_oe_n, io23_quad_mode;
    logic           wp_active_n, reset_fn_active, nv_qe_write, quad_cmd_accept;
    logic           buf1_write_accept, buf2_write_accept;
    logic [15:0]    st;
    logic [7:0]     rx;
    fsc_op_result_t op_result;
    wire logic      cs_n, sck, si;
    wire logic      so_w = so_oe_n ? 1'bz : so_out;
    int             n_errors, num_checks, cyc_n, n_qa, n_b1, n_b2, n_nv, n_oe, n;
    // Rows: {protect, lock off, binary, ps1, ps2, es} then expected status bits
    logic [11:0]    rows [4] = '{12'h008, 12'hFF7, 12'h96B, 12'h694};

    fsc_spi_host fsc_spi_host_inst (.cs_n(cs_n), .sck(sck), .si(si), .so(so_w));
    fsc_regs fsc_regs_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cs_n_pin(cs_n), .sck_pin(sck),
        .si_pin(si), .so_out(so_out), .so_oe_n(so_oe_n), .io23_quad_mode(io23_quad_mode),
        .wp_active_n(wp_active_n), .wp_pin_n(wp_pin_n), .reset_fn_active(reset_fn_active),
        .array_busy(array_busy), .op_result(op_result), .sw_protect_en(sw_protect_en),
        .lockdown_disabled(lockdown_disabled), .page_is_binary(page_is_binary),
        .buf1_prog_susp(buf1_prog_susp), .buf2_prog_susp(buf2_prog_susp),
        .erase_susp(erase_susp), .soft_reset(soft_reset), .nv_qe_valid(nv_qe_valid),
        .nv_qe_value(nv_qe_value), .nv_qe_write(nv_qe_write), .quad_cmd_accept(quad_cmd_accept),
        .buf1_write_accept(buf1_write_accept), .buf2_write_accept(buf2_write_accept),
        .device_status_flags(st));

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #5;
    endtask
    // One frame of the low nb bytes of b, the highest of them sent first
    task automatic cmd(input logic [31:0] b, input int nb);
        fsc_spi_host_inst.sel();
        for (int i = nb - 1; i >= 0; i--) fsc_spi_host_inst.xfer(b[8*i +: 8], 8, rx);
        fsc_spi_host_inst.desel();
        cyc(2);
    endtask
    // Host polls ready before going on
    task automatic wait_rdy();
        int k = 0;
        while (st[ST_RDY] !== 1'b1 && k < 22000) begin
            cyc(1);
            k++;
        end
        chk(k < 22000, "ready never returned");
    endtask
    // Two whole bytes then a cut-off one
    task automatic cfg_rd(input logic [7:0] exp);
        fsc_spi_host_inst.sel();
        fsc_spi_host_inst.xfer(OP_CFG_READ, 8, rx);
        for (int i = 0; i < 2; i++) begin
            fsc_spi_host_inst.xfer(8'h00, 8, rx);
            chk(rx === exp, "config byte");
        end
        fsc_spi_host_inst.xfer(8'h00, 3, rx);
        fsc_spi_host_inst.desel();
        cyc(8);
        chk(so_oe_n === 1'b1, "output not released");
    endtask
    // Pulse one engine result and check the error flag
    task automatic op(input fsc_op_result_t r, input logic e);
        op_result = r;
        cyc(1);
        op_result = '0;
        cyc(4);
        chk(st[ST_EPE] === e, "error flag");
    endtask

    // Pulse counters and run limit
    always @(posedge clk_sys) begin
        cyc_n++;
        if (quad_cmd_accept) n_qa++;
        if (buf1_write_accept) n_b1++;
        if (buf2_write_accept) n_b2++;
        if (nv_qe_write) n_nv++;
        if (!so_oe_n) n_oe++;
        if (cyc_n == 60000) begin
            chk(1'b0, "timeout");
            conclude();
        end
    end

    initial begin
        {rst_n, array_busy, soft_reset, sw_protect_en, lockdown_disabled, page_is_binary} = '0;
        {erase_susp, buf1_prog_susp, buf2_prog_susp, nv_qe_value, op_result} = '0;
        {clk_en, wp_pin_n, nv_qe_valid} = 3'b111;
        cyc(2);
        rst_n = 1'b1;
        cyc(6);
        chk(so_oe_n === 1'b1 && reset_fn_active === 1'b1, "reset state");
        foreach (rows[k]) begin
            {sw_protect_en, lockdown_disabled, page_is_binary, buf1_prog_susp, buf2_prog_susp,
                erase_susp} = rows[k][11:6];
            cyc(6);
            chk({st[ST_RDY], st[ST_PROT], st[ST_PSIZE], st[ST_SLE], st[ST_PS2], st[ST_PS1],
                st[ST_ES]} === {1'b1, rows[k][5:0]}, "status row");
        end
        {sw_protect_en, buf1_prog_susp, buf2_prog_susp, erase_susp} = '0;
        wp_pin_n = 1'b0;
        cyc(6);
        chk(wp_active_n === 1'b0 && st[ST_PROT] === 1'b1, "pin protect");
        wp_pin_n = 1'b1;
        cfg_rd(8'h08);
        n = n_qa;
        cmd(OP_QUAD_READ, 1);
        chk(n_qa == n, "quad opcode taken while off");
        cmd(32'h003D2A81, 3);
        cmd(32'h3D2A8165, 4);
        chk(st[ST_RDY] === 1'b1 && n_nv == 0, "bad sequence acted on");
        array_busy = 1'b1;
        cyc(6);
        chk(st[ST_RDY] === 1'b0, "ready while busy");
        n = n_oe;
        cmd({16'h0000, OP_CFG_READ, 8'h00}, 2);
        chk(n_oe == n, "config read while busy");
        array_busy = 1'b0;
        cmd(32'h3D2A8166, 4);
        chk(st[ST_RDY] === 1'b0, "no busy during write");
        wait_rdy();
        chk(io23_quad_mode === 1'b1 && n_nv == 1, "quad set");
        cfg_rd(8'h88);
        n = n_qa;
        cmd(OP_QUAD_READ, 1);
        wp_pin_n = 1'b0;
        cyc(6);
        chk(n_qa == n + 1 && wp_active_n === 1'b1, "quad mode");
        wp_pin_n = 1'b1;
        soft_reset = 1'b1;
        cyc(1);
        soft_reset = 1'b0;
        cyc(2);
        chk(io23_quad_mode === 1'b1, "quad lost on soft reset");
        nv_qe_value = 1'b1;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(6);
        chk(io23_quad_mode === 1'b1, "quad lost on reset");
        cmd(32'h3D2A8167, 4);
        wait_rdy();
        chk(io23_quad_mode === 1'b0 && reset_fn_active === 1'b1, "quad clear");
        {buf1_prog_susp, buf2_prog_susp} = 2'b11;
        cmd(OP_BUF1_WRITE, 1);
        cmd(OP_BUF2_WRITE, 1);
        chk(n_b1 == 0 && n_b2 == 0, "write while suspended");
        {buf1_prog_susp, buf2_prog_susp} = 2'b00;
        cmd(OP_BUF1_WRITE, 1);
        cmd(OP_BUF2_WRITE, 1);
        chk(n_b1 == 1 && n_b2 == 1, "write refused");
        op('{1'b1, 1'b1, 1'b0}, 1'b1);
        op('{1'b1, 1'b0, 1'b1}, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
